// File: bench/rirq_chk.sv
// Checker of the status block port relations
`timescale 1ns/100ps
module rirq_chk
  import rirq_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chip_enable,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic protocol_write,
  input wire logic tx_end,
  input wire logic rx_end,
  input wire logic fifo_check,
  input wire logic crc_error,
  input wire logic parity_error,
  input wire logic framing_error,
  input wire logic collision,
  input wire logic no_response,
  input wire logic irq_q
);
  wire ev = tx_end | rx_end | fifo_check | crc_error | parity_error |
    framing_error | collision | no_response;
  wire rd_c = reg_rd && reg_addr == RIRQ_OFS_CAUSE;
  wire rd_e = reg_rd && reg_addr == RIRQ_OFS_ENABLE;
  wire rd_p = reg_rd && reg_addr == RIRQ_OFS_COLPOS;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_tx;
    tx_end && chip_enable && !protocol_write |=> irq_q;
  endproperty
  a_tx: assert property (p_tx) else $error("tx end");
  property p_rx;
    rx_end && chip_enable && !protocol_write |=> irq_q;
  endproperty
  a_rx: assert property (p_rx) else $error("rx end");
  property p_ce;
    !chip_enable |=> !irq_q;
  endproperty
  a_ce: assert property (p_ce) else $error("enable low");
  property p_rc;
    rd_c && !ev && !$past(ev) |=> !irq_q;
  endproperty
  a_rc: assert property (p_rc) else $error("cause read");
  property p_zr;
    !chip_enable ##1 (rd_c || rd_p) |=> reg_rdata_q == 8'h00;
  endproperty
  a_zr: assert property (p_zr) else $error("zero reset");
  property p_en;
    !chip_enable ##1 rd_e |=> reg_rdata_q == RIRQ_RST_ENABLE;
  endproperty
  a_en: assert property (p_en) else $error("enable reset");
  property p_cp;
    rd_p && !ev && !$past(ev) ##1 rd_p |=> reg_rdata_q == 8'h00;
  endproperty
  a_cp: assert property (p_cp) else $error("position kept");
  property p_ro;
    $rose(irq_q) |-> $past(ev) || $past(ev, 2) || $past(reg_wr) ||
      $past(reg_wr, 2);
  endproperty
  a_ro: assert property (p_ro) else $error("spurious request");
  c_irq: cover property ($rose(irq_q));
  c_cp: cover property (rd_p ##1 rd_p);
  c_ce: cover property (!chip_enable ##1 rd_e);
endmodule
bind rirq_status rirq_chk rirq_chk_i (.clk(clk), .sys_rst(sys_rst),
  .chip_enable(chip_enable), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .protocol_write(protocol_write), .tx_end(tx_end), .rx_end(rx_end),
  .fifo_check(fifo_check), .crc_error(crc_error),
  .parity_error(parity_error), .framing_error(framing_error),
  .collision(collision), .no_response(no_response), .irq_q(irq_q));

// File: bench/rirq_host.sv
// Host model driving the register port
`timescale 1ns/100ps
module rirq_host (
  input wire logic clk,
  input wire logic [7:0] reg_rdata_q,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask
  task automatic rd2(input logic [7:0] a, input logic [7:0] b,
    output logic [7:0] d1, output logic [7:0] d2);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_addr <= b;
    #1 d1 = reg_rdata_q;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d2 = reg_rdata_q;
  endtask
endmodule

// File: bench/rirq_status_test.sv
// Self-checking bench of the status block
`timescale 1ns/100ps
module rirq_status_test
  import rirq_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic cp = 1'b1;
  logic swap = 1'b0;
  logic osc = 1'b1;
  logic rfo = 1'b0;
  logic [10:0] pv = 11'h000;
  logic [3:0] lvl = 4'h3;
  logic [9:0] pos = 10'h000;
  logic [2:0] am = 3'h5;
  logic [2:0] pm = 3'h2;
  logic [5:0] amp = 6'h2C;
  logic [7:0] ra, rw, rd;
  logic wr_s, rd_s, irq;
  int err_total = 0;
  int num_checks = 0;
  always #2 clk = ~clk;
  rirq_host rirq_host_i (.clk(clk), .reg_rdata_q(rd), .reg_addr(ra),
    .reg_wdata(rw), .reg_wr(wr_s), .reg_rd(rd_s));
  rirq_status rirq_status_i (.clk(clk), .sys_rst(sys_rst),
    .chip_enable(ce), .reg_addr(ra), .reg_wdata(rw), .reg_wr(wr_s),
    .reg_rd(rd_s), .reg_rdata_q(rd), .protocol_write(pv[10]),
    .collision_protocol(cp), .swap_channels(swap), .tx_start(pv[9]),
    .tx_end(pv[8]), .rx_sof(pv[7]), .rx_end(pv[6]), .fifo_level(lvl),
    .fifo_check(pv[5]), .crc_error(pv[4]), .parity_error(pv[3]),
    .framing_error(pv[2]), .collision(pv[1]), .no_response(pv[0]),
    .event_position(pos), .osc_stable(osc), .rf_off(rfo), .am_level(am),
    .pm_level(pm), .rf_amplitude(amp), .irq_q(irq));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rirq_host_i.rd(a, d);
    chk(d, e);
  endtask
  task automatic cr(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    ce <= 1'b0;
    fork
      rc(a, e);
      begin @(posedge clk); ce <= 1'b1; end
    join
  endtask
  task automatic pl(input logic [10:0] v);
    @(posedge clk);
    pv <= v;
    @(posedge clk);
    pv <= 11'h000;
  endtask
  task automatic ci(input logic e);
    @(posedge clk);
    #1 chk({7'h00, irq}, {7'h00, e});
  endtask
  task automatic rc2(input logic [7:0] a, input logic [7:0] e1,
    input logic [7:0] e2);
    logic [7:0] d1;
    logic [7:0] d2;
    rirq_host_i.rd2(a, a, d1, d2);
    chk(d1, e1);
    chk(d2, e2);
  endtask
  task automatic t_reg();
    rc(RIRQ_OFS_CAUSE, 8'h00);
    rc(RIRQ_OFS_ENABLE, 8'h3E);
    rc(RIRQ_OFS_COLPOS, 8'h00);
    rirq_host_i.wr(RIRQ_OFS_ENABLE, 8'hFF);
    rc(RIRQ_OFS_ENABLE, 8'h3F);
    rirq_host_i.wr(RIRQ_OFS_CAUSE, 8'hFF);
    rc(RIRQ_OFS_CAUSE, 8'h00);
    rc(8'h20, 8'h00);
    rirq_host_i.wr(RIRQ_OFS_ENABLE, RIRQ_RST_ENABLE);
    $display("done registers");
  endtask
  task automatic t_str();
    rc(RIRQ_OFS_STRENGTH, 8'h55);
    swap <= 1'b1;
    rc(RIRQ_OFS_STRENGTH, 8'h6A);
    swap <= 1'b0;
    pl(11'h080);
    pl(11'h040);
    am <= 3'h1;
    rc(RIRQ_OFS_STRENGTH, 8'h55);
    pl(11'h200);
    rc(RIRQ_OFS_STRENGTH, 8'h51);
    rc(RIRQ_OFS_CAUSE, 8'hC0);
    rfo <= 1'b1;
    rc(RIRQ_OFS_STRENGTH, 8'h6C);
    osc <= 1'b0;
    rc(RIRQ_OFS_STRENGTH, 8'h2C);
    rfo <= 1'b0;
    osc <= 1'b1;
    $display("done strength");
  endtask
  task automatic t_txrx();
    pl(11'h200);
    ci(1'b0);
    rc(RIRQ_OFS_CAUSE, 8'h80);
    pl(11'h200);
    pl(11'h100);
    ci(1'b1);
    rc(RIRQ_OFS_CAUSE, 8'h80);
    chk({7'h00, irq}, 8'h00);
    pl(11'h080);
    pl(11'h040);
    ci(1'b1);
    rc(RIRQ_OFS_CAUSE, 8'h40);
    $display("done transfer");
  endtask
  task automatic t_cause();
    for (int i = 0; i < 6; i++) begin
      pl({5'h00, 6'h01 << i});
      ci(RIRQ_RST_ENABLE[i]);
      rc(RIRQ_OFS_CAUSE, 8'h01 << i);
    end
    rc(RIRQ_OFS_COLPOS, 8'h00);
    rc(RIRQ_OFS_ENABLE, 8'h3E);
    lvl <= 4'h4;
    pl(11'h020);
    rc(RIRQ_OFS_CAUSE, 8'h00);
    lvl <= 4'h8;
    pl(11'h020);
    rc(RIRQ_OFS_CAUSE, 8'h00);
    lvl <= 4'h9;
    pl(11'h020);
    rc(RIRQ_OFS_CAUSE, 8'h20);
    $display("done causes");
  endtask
  task automatic t_col();
    pos <= 10'h2A5;
    pl(11'h002);
    rc2(RIRQ_OFS_COLPOS, 8'hA5, 8'h00);
    rc2(RIRQ_OFS_ENABLE, 8'hBE, 8'h3E);
    rc(RIRQ_OFS_CAUSE, 8'h02);
    cp <= 1'b0;
    pl(11'h002);
    rc(RIRQ_OFS_CAUSE, 8'h00);
    pos <= 10'h15A;
    pl(11'h010);
    rc(RIRQ_OFS_COLPOS, 8'h5A);
    rc(RIRQ_OFS_ENABLE, 8'h7E);
    rc(RIRQ_OFS_CAUSE, 8'h10);
    $display("done position");
  endtask
  task automatic t_clr();
    pl(11'h010);
    ci(1'b1);
    pl(11'h400);
    ci(1'b0);
    rc(RIRQ_OFS_CAUSE, 8'h00);
    pl(11'h010);
    cr(RIRQ_OFS_CAUSE, 8'h00);
    rirq_host_i.wr(RIRQ_OFS_ENABLE, 8'h00);
    pl(11'h010);
    cr(RIRQ_OFS_ENABLE, 8'h3E);
    pl(11'h010);
    cr(RIRQ_OFS_COLPOS, 8'h00);
    $display("done clearing");
  endtask
  task automatic t_rst();
    rirq_host_i.wr(RIRQ_OFS_ENABLE, 8'h10);
    pl(11'h010);
    ci(1'b1);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    ci(1'b0);
    rc(RIRQ_OFS_CAUSE, 8'h00);
    rc(RIRQ_OFS_ENABLE, 8'h3E);
    rc(RIRQ_OFS_COLPOS, 8'h00);
    $display("done reset");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_reg();
    t_str();
    t_txrx();
    t_cause();
    t_col();
    t_clr();
    t_rst();
    final_report();
  end
  initial begin
    #100000;
    err_total++;
    final_report();
  end
endmodule

// File: hdl/rirq_pkg.sv
// Package of offsets, field positions and reset values for the status block
package rirq_pkg;
  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] RIRQ_OFS_CAUSE = 8'h0C;
  localparam logic [7:0] RIRQ_OFS_ENABLE = 8'h0D;
  localparam logic [7:0] RIRQ_OFS_COLPOS = 8'h0E;
  localparam logic [7:0] RIRQ_OFS_STRENGTH = 8'h0F;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RIRQ_RST_CAUSE = 8'h00;
  localparam logic [7:0] RIRQ_RST_ENABLE = 8'h3E;
  localparam logic [7:0] RIRQ_RST_COLPOS = 8'h00;
  // ------------------------------------------------------------
  // Cause bit positions, then oscillator and swap bit positions
  // ------------------------------------------------------------
  localparam int RIRQ_B_TX = 7;
  localparam int RIRQ_B_RX = 6;
  localparam int RIRQ_B_FIFO = 5;
  localparam int RIRQ_B_CRC = 4;
  localparam int RIRQ_B_PARITY = 3;
  localparam int RIRQ_B_FRAMING = 2;
  localparam int RIRQ_B_COL = 1;
  localparam int RIRQ_B_NORESP = 0;
  localparam int RIRQ_B_OSC = 6;
  localparam int RIRQ_B_SWAP = 3;
  // ------------------------------------------------------------
  // FIFO level thresholds
  // ------------------------------------------------------------
  localparam logic [3:0] RIRQ_FIFO_LOW = 4'h4;
  localparam logic [3:0] RIRQ_FIFO_HIGH = 4'h8;
  // ------------------------------------------------------------
  // Transmit and receive phase
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    RIRQ_IDLE = 2'b00,
    RIRQ_TX = 2'b01,
    RIRQ_RX = 2'b10
  } rirq_phase_e;
endpackage

// File: hdl/rirq_status.sv
// Interrupt cause, enable, collision position and strength registers
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
//
// Overview of operation
// (R1) Cause register clears on reset, enable pin low, protocol select write.
// (R2) Reading the cause register clears it and drops the request.
// (R3) Transmit flag sets at transmit start; request raised at its end.
// (R4) Receive flag sets at start-of-frame; request raised at receive end.
// (R5) FIFO cause sets when level below 4 or above 8 bytes.
// (R6) CRC, parity and framing errors set bits 4, 3 and 2.
// (R7) Collision cause only in the two collision-reporting protocols.
// (R8) No-response cause in bit 0 signals next time slot allowed.
// (R9) Enable register resets to 0x3E.
// (R10) Enable bits 5..0 gate FIFO, CRC, parity, framing, collision, no-resp.
// (R11) Collision position is ten bits, split over two registers.
// (R12) Collision position clears after the host reads it.
// (R13) Other protocols report error bit position in the same register.
// (R14) Low position register resets to 0x00.
// (R15) Strength is two 3-bit values, active low bits, auxiliary above.
// (R16) Swap control exchanges amplitude and phase channels.
// (R17) Strength held from receive start until next transmit start.
// (R18) Oscillator stable shows in bit 6 of strength register.
// (R19) With field off the strength register shows RF amplitude.
// (R20) Request asserted while an enabled cause is pending.
module rirq_status
  import rirq_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chip_enable,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  input wire logic protocol_write,
  input wire logic collision_protocol,
  input wire logic swap_channels,
  input wire logic tx_start,
  input wire logic tx_end,
  input wire logic rx_sof,
  input wire logic rx_end,
  input wire logic [3:0] fifo_level,
  input wire logic fifo_check,
  input wire logic crc_error,
  input wire logic parity_error,
  input wire logic framing_error,
  input wire logic collision,
  input wire logic no_response,
  input wire logic [9:0] event_position,
  input wire logic osc_stable,
  input wire logic rf_off,
  input wire logic [2:0] am_level,
  input wire logic [2:0] pm_level,
  input wire logic [5:0] rf_amplitude,
  output logic irq_q
);
  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic soft_clr;
  logic rd_cause;
  logic rd_enable;
  logic rd_colpos;
  logic rd_strength;
  logic wr_enable;
  logic col_ok;
  logic err_any;
  logic pos_load;
  logic fifo_out;

  // Strobe qualified by a register offset
  function automatic logic addr_hit(input logic strobe,
    input logic [7:0] addr,
    input logic [7:0] ofs);
    return strobe && (addr == ofs);
  endfunction

  assign soft_clr = !chip_enable;
  assign rd_cause = addr_hit(reg_rd, reg_addr, RIRQ_OFS_CAUSE);
  assign rd_enable = addr_hit(reg_rd, reg_addr, RIRQ_OFS_ENABLE);
  assign rd_colpos = addr_hit(reg_rd, reg_addr, RIRQ_OFS_COLPOS);
  assign rd_strength = addr_hit(reg_rd, reg_addr, RIRQ_OFS_STRENGTH);
  assign wr_enable = addr_hit(reg_wr, reg_addr, RIRQ_OFS_ENABLE);
  assign col_ok = collision && collision_protocol; // (R7)
  assign err_any = crc_error || parity_error || framing_error;
  assign pos_load = col_ok || (err_any && !collision_protocol); // (R13)
  assign fifo_out = fifo_check && ((fifo_level < RIRQ_FIFO_LOW) ||
                    (fifo_level > RIRQ_FIFO_HIGH)); // (R5)

  // ------------------------------------------------------------
  // Cause register
  // ------------------------------------------------------------
  logic [7:0] cause_q;
  logic [7:0] cause_set;
  logic [7:0] cause_d;
  logic [7:0] cause_base;

  assign cause_set = {tx_start, rx_sof, fifo_out, crc_error,
                      parity_error, framing_error, col_ok,
                      no_response}; // (R3) (R4) (R6) (R8)
  assign cause_base = (rd_cause || protocol_write) ? RIRQ_RST_CAUSE :
                      cause_q; // (R1) (R2)
  assign cause_d = cause_base | cause_set;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cause_q <= RIRQ_RST_CAUSE; // (R1)
    end else if (soft_clr) begin
      cause_q <= RIRQ_RST_CAUSE; // (R1)
    end else begin
      cause_q <= cause_d;
    end
  end

  // ------------------------------------------------------------
  // Transmit and receive completion
  // ------------------------------------------------------------
  rirq_phase_e phase_q;
  rirq_phase_e phase_d;
  logic done_q;
  logic done_d;

  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      RIRQ_IDLE: begin
        if (tx_start) begin
          phase_d = RIRQ_TX;
        end else if (rx_sof) begin
          phase_d = RIRQ_RX;
        end
      end
      RIRQ_TX: begin
        if (tx_end) begin
          phase_d = RIRQ_IDLE;
        end
      end
      RIRQ_RX: begin
        if (rx_end) begin
          phase_d = RIRQ_IDLE;
        end
      end
      default: begin
        phase_d = RIRQ_IDLE;
      end
    endcase
  end

  assign done_d = ((phase_q == RIRQ_TX) && tx_end) ||
                  ((phase_q == RIRQ_RX) && rx_end) ||
                  (done_q && !(rd_cause || protocol_write)); // (R3) (R4)

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q <= RIRQ_IDLE;
      done_q <= 1'b0;
    end else if (soft_clr) begin
      phase_q <= RIRQ_IDLE;
      done_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      done_q <= done_d;
    end
  end

  // ------------------------------------------------------------
  // Enable and collision position
  // ------------------------------------------------------------
  logic [5:0] enable_q;
  logic [9:0] colpos_q;
  logic [9:0] colpos_d;
  logic [9:0] colpos_base;

  assign colpos_base = rd_colpos ? {colpos_q[9:8], 8'h00} :
                       (rd_enable ? {2'b00, colpos_q[7:0]} :
                       colpos_q); // (R12)
  assign colpos_d = pos_load ? event_position : colpos_base; // (R11)

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_q <= RIRQ_RST_ENABLE[5:0]; // (R9)
      colpos_q <= {RIRQ_RST_ENABLE[7:6], RIRQ_RST_COLPOS}; // (R14)
    end else if (soft_clr) begin
      enable_q <= RIRQ_RST_ENABLE[5:0]; // (R9)
      colpos_q <= {RIRQ_RST_ENABLE[7:6], RIRQ_RST_COLPOS}; // (R14)
    end else begin
      if (wr_enable) begin
        enable_q <= reg_wdata[5:0];
      end
      colpos_q <= colpos_d;
    end
  end

  // ------------------------------------------------------------
  // Signal strength
  // ------------------------------------------------------------
  logic [5:0] strength_w;

  rirq_strength rirq_strength_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr(soft_clr),
    .swap(swap_channels), // (R16)
    .rf_off(rf_off), // (R19)
    .rx_start(rx_sof),
    .tx_start(tx_start),
    .am_level(am_level),
    .pm_level(pm_level),
    .rf_amplitude(rf_amplitude),
    .strength_q(strength_w)
  );

  // ------------------------------------------------------------
  // Interrupt request and read data
  // ------------------------------------------------------------
  logic irq_d;
  logic [7:0] rdata_d;
  logic [7:0] strength_byte;

  assign irq_d = !soft_clr && (done_d ||
                 (|(cause_d[5:0] & enable_q))); // (R10) (R20)
  assign strength_byte = {1'b0, osc_stable, strength_w}; // (R15) (R18)
  assign rdata_d = rd_cause ? cause_q :
                   rd_enable ? {colpos_q[9:8], enable_q} :
                   rd_colpos ? colpos_q[7:0] :
                   rd_strength ? strength_byte : 8'h00;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
      reg_rdata_q <= 8'h00;
    end else begin
      irq_q <= irq_d; // (R2) (R20)
      reg_rdata_q <= rdata_d;
    end
  end
endmodule

// File: hdl/rirq_strength.sv
// Signal strength capture with channel swap and field-off amplitude
`timescale 1ns/100ps
module rirq_strength
  import rirq_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clr,
  input wire logic swap,
  input wire logic rf_off,
  input wire logic rx_start,
  input wire logic tx_start,
  input wire logic [2:0] am_level,
  input wire logic [2:0] pm_level,
  input wire logic [5:0] rf_amplitude,
  output logic [5:0] strength_q
);
  logic hold_q;
  logic [5:0] chan_w;
  logic [5:0] strength_d;

  assign chan_w = swap ? {am_level, pm_level} : {pm_level, am_level};
  assign strength_d = rf_off ? rf_amplitude :
                      (hold_q ? strength_q : chan_w);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_q <= 1'b0;
      strength_q <= 6'h00;
    end else if (clr) begin
      hold_q <= 1'b0;
      strength_q <= 6'h00;
    end else begin
      if (rx_start) begin
        hold_q <= 1'b1; // (R17)
      end else if (tx_start) begin
        hold_q <= 1'b0; // (R17)
      end
      strength_q <= (rx_start && !rf_off) ? chan_w : strength_d;
    end
  end
endmodule
